// ===== sdr_host_model.sv
// sdr_host_model: host side of continuous transmit on io line 2.
// assumes the bit clock arrives on io line 1 and our clock samples it.
`timescale 1ns/100ps
module sdr_host_model (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic dclk_i,
  input wire logic en_i,
  input wire logic [7:0] byte_i,
  output logic data_o
);
  logic dclk_q; // bit clock one cycle ago, for edge finding
  logic [2:0] idx_r; // bit being presented now, msb first
  // step to the next bit just after the clock falls, far from the rise
  always_ff @(posedge clk_i) begin
    dclk_q <= dclk_i;
    if (!reset_n_i || !en_i) idx_r <= 3'h7;
    else if (dclk_q && !dclk_i) idx_r <= idx_r - 3'h1;
  end
  // released line toggles, so nothing can match by accident
  assign data_o = en_i ? byte_i[idx_r] : ~dclk_q;
endmodule : sdr_host_model

// ===== sdr_pkg.sv
// sdr_pkg: constants, enumerations and carriers for the sync detector
// and io routing block.
// assumes one 10 MHz clock and an 8-bit register port with 5-bit address.
package sdr_pkg;

  // timing: bit clock period on the link and our own clock period
  localparam int CLK_PERIOD_NS = 100;
  localparam int BIT_CLK_PERIOD_NS = 800;
  // half a bit clock period in our cycles, rounded down, at least one
  localparam int BCLK_HALF_CYC = (BIT_CLK_PERIOD_NS / CLK_PERIOD_NS / 2) < 1 ?
    1 : (BIT_CLK_PERIOD_NS / CLK_PERIOD_NS / 2);

  // register offsets
  localparam logic [4:0] A_OPMODE = 5'h00;
  localparam logic [4:0] A_SYNC = 5'h01;
  localparam logic [4:0] A_PAT0 = 5'h02;
  localparam logic [4:0] A_PAT7 = 5'h09;
  localparam logic [4:0] A_MAP_A = 5'h0a;
  localparam logic [4:0] A_MAP_B = 5'h0b;
  localparam logic [4:0] A_IRQ_ST = 5'h0c;
  localparam logic [4:0] A_IRQ_MSK = 5'h0d;
  localparam logic [4:0] A_STATUS = 5'h0e;

  // field positions
  localparam int OP_MODE_LSB = 0;
  localparam int OP_CONT_BIT = 3;
  localparam int OP_BSYNC_BIT = 4;
  localparam int SYNC_EN_BIT = 7;
  localparam int SYNC_LEN_LSB = 3;
  localparam int SYNC_TOL_LSB = 0;
  localparam int IRQ_MATCH_BIT = 0;
  localparam int IRQ_QCLR_BIT = 1;

  // reset values
  localparam logic [7:0] OP_RST = 8'h01;
  localparam logic [7:0] SYNC_RST = 8'h98;
  localparam logic [7:0] PAT_RST = 8'h01;
  localparam logic [7:0] MAP_RST = 8'h00;
  localparam logic [1:0] IRQ_RST = 2'h0;

  // operating modes, in the order of the mode field encoding
  typedef enum logic [2:0] {
    M_SLEEP, M_STDBY, M_FS, M_TX, M_RX
  } sdr_mode_t;

  // signals that a mapping code can route to an io line
  typedef enum logic [4:0] {
    SRC_NONE, SRC_MRDY, SRC_CLKO, SRC_PLL, SRC_AUTO, SRC_TMO, SRC_RSSI,
    SRC_DATA, SRC_DCLK, SRC_SYNC, SRC_RXR, SRC_TXR, SRC_FULL, SRC_NEMP,
    SRC_LVL, SRC_CRC, SRC_SENT, SRC_PRDY
  } sdr_src_t;

  // status from the rest of the transceiver, same clock domain
  typedef struct packed {
    logic mode_settled;
    logic reference_clock_out;
    logic synth_locked;
    logic auto_sequence_active;
    logic timeout;
    logic rssi;
    logic receive_ready;
    logic transmit_ready;
    logic queue_full;
    logic queue_nonempty;
    logic queue_threshold_hit;
    logic checksum_good;
    logic frame_sent;
    logic frame_ready;
    logic tx_data;
  } sdr_stat_t;

  // sync setup handed to the packet transmitter
  typedef struct packed {
    logic enable;
    logic [2:0] len_m1;
    logic [2:0] tol;
    logic [63:0] pattern;
  } sdr_sync_cfg_t;

endpackage : sdr_pkg

// ===== sdr_sync_io.sv
// sdr_sync_io: sync word correlator, queue clear on mode change, io line
// routing and continuous-mode bit clock with serial data capture.
// assumes status inputs and demod bits come from logic on clk_i; the io
// line 2 input is a pin and is synchronised here.
// How it works
// - queue kept or cleared per mode transition
// - detector runs only when enabled, bitsync in continuous
// - shift register compares each new bit window
// - oldest bit meets pattern byte one bit seven
// - match flag clears leaving receive or queue empty
// - length field picks one to eight bytes
// - tolerance allows zero to seven bit errors
// - sixty-four bit pattern shared with transmitter
// - six io lines routed by two-bit codes
// - continuous: line two data, clock, settled
// - packet code zero: queue flags and line zero
// - packet receive data gated between ready edges
// - continuous mode without bitsync moves raw data on line two
// - transmit bit clock out, data taken rising
// - receive data changes on falling bit clock
`timescale 1ns/100ps
module sdr_sync_io (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [4:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  output logic irq_o,
  input wire sdr_pkg::sdr_stat_t stat_i,
  input wire logic rx_bit_i,
  input wire logic rx_bit_vld_i,
  input wire logic io2_i,
  output logic [5:0] io_o,
  output logic [5:0] io_oe_o,
  output logic queue_clear_o,
  output logic sync_match_o,
  output logic tx_bit_o,
  output logic tx_bit_vld_o,
  output sdr_pkg::sdr_sync_cfg_t sync_cfg_o
);

  // short aliases keep the routing table readable
  localparam sdr_pkg::sdr_src_t NO = sdr_pkg::SRC_NONE;
  localparam sdr_pkg::sdr_src_t MR = sdr_pkg::SRC_MRDY;
  localparam sdr_pkg::sdr_src_t CK = sdr_pkg::SRC_CLKO;
  localparam sdr_pkg::sdr_src_t PL = sdr_pkg::SRC_PLL;
  localparam sdr_pkg::sdr_src_t AM = sdr_pkg::SRC_AUTO;
  localparam sdr_pkg::sdr_src_t TO = sdr_pkg::SRC_TMO;
  localparam sdr_pkg::sdr_src_t RS = sdr_pkg::SRC_RSSI;
  localparam sdr_pkg::sdr_src_t DA = sdr_pkg::SRC_DATA;
  localparam sdr_pkg::sdr_src_t DC = sdr_pkg::SRC_DCLK;
  localparam sdr_pkg::sdr_src_t SY = sdr_pkg::SRC_SYNC;
  localparam sdr_pkg::sdr_src_t RR = sdr_pkg::SRC_RXR;
  localparam sdr_pkg::sdr_src_t TR = sdr_pkg::SRC_TXR;
  localparam sdr_pkg::sdr_src_t FF = sdr_pkg::SRC_FULL;
  localparam sdr_pkg::sdr_src_t FE = sdr_pkg::SRC_NEMP;
  localparam sdr_pkg::sdr_src_t FL = sdr_pkg::SRC_LVL;
  localparam sdr_pkg::sdr_src_t CO = sdr_pkg::SRC_CRC;
  localparam sdr_pkg::sdr_src_t PS = sdr_pkg::SRC_SENT;
  localparam sdr_pkg::sdr_src_t PR = sdr_pkg::SRC_PRDY;
  localparam logic [2:0] HALF_M1 = 3'(sdr_pkg::BCLK_HALF_CYC - 1);

  // routing row {io5..io0} for one data mode, mode and code; key {mode,code}
  function automatic logic [29:0] route_row(input logic cont,
      input logic [2:0] mode, input logic [1:0] code);
    logic [29:0] r;
    r = {NO, NO, NO, NO, NO, NO};
    if (cont) begin
      case ({mode, code})
        5'h02, 5'h06, 5'h0a: r = {NO, NO, AM, NO, NO, NO};
        5'h03, 5'h07: r = {MR, NO, NO, NO, NO, MR};
        5'h04: r = {CK, NO, NO, NO, NO, NO};
        5'h08: r = {CK, NO, NO, NO, NO, PL};
        5'h0b: r = {MR, PL, NO, NO, PL, MR};
        5'h0c: r = {CK, TR, TR, DA, DC, PL};
        5'h0d: r = {CK, TR, TR, DA, TR, TR};
        5'h0e: r = {NO, NO, AM, DA, NO, NO};
        5'h0f: r = {MR, PL, TR, DA, PL, MR};
        5'h10: r = {CK, TO, RS, DA, DC, SY};
        5'h11: r = {RS, RR, RR, DA, RR, TO};
        5'h12: r = {NO, SY, AM, DA, NO, RS};
        5'h13: r = {MR, PL, TO, DA, SY, MR};
        default: r = {NO, NO, NO, NO, NO, NO};
      endcase
    end else begin
      case ({mode, code})
        5'h00: r = {NO, NO, FF, FE, FL, NO};
        5'h04, 5'h08: r = {CK, NO, FF, FE, FL, NO};
        5'h01, 5'h05, 5'h09: r = {NO, NO, NO, NO, FF, NO};
        5'h02, 5'h06, 5'h0a, 5'h0e: r = {NO, NO, NO, NO, FE, NO};
        5'h03, 5'h07: r = {MR, NO, NO, AM, NO, NO};
        5'h0b, 5'h0f: r = {MR, PL, PL, AM, PL, PL};
        5'h0c: r = {CK, MR, FF, FE, FL, PS};
        5'h0d: r = {DA, TR, TR, DA, FF, TR};
        5'h10: r = {CK, TO, FF, FE, FL, CO};
        5'h11: r = {DA, RS, RS, DA, FF, PR};
        5'h12: r = {NO, RR, SY, NO, FE, SY};
        5'h13: r = {MR, PL, PL, AM, TO, RS};
        default: r = {NO, NO, NO, NO, NO, NO};
      endcase
    end
    return r;
  endfunction : route_row

  // count of ones, used for the mismatch count of the correlator
  function automatic logic [6:0] ones(input logic [63:0] v);
    logic [6:0] n;
    n = 7'h00;
    for (int i = 0; i < 64; i++) begin
      n = n + 7'(v[i]);
    end
    return n;
  endfunction : ones

  // software registers
  logic [7:0] op_r; // mode, data mode, bit synchroniser enable
  logic [7:0] sync_r; // detect enable, length, tolerance
  logic [7:0] pat_r [8]; // pattern bytes, index 0 is the first byte
  logic [7:0] map_a_r; // codes for io lines 0..3
  logic [7:0] map_b_r; // codes for io lines 4..5
  logic [1:0] ist_r; // sticky event bits
  logic [1:0] imsk_r; // event mask
  logic [7:0] rdata_r;
  logic irq_r;

  // block state
  logic [2:0] prev_mode_r; // mode seen last cycle
  logic qclr_r; // one-cycle queue clear pulse
  logic [63:0] shift_r; // received bit window, newest in bit 0
  logic [6:0] nbits_r; // bits gathered since the detector started
  logic match_r; // sync match flag
  logic nemp_q_r; // queue nonempty, last cycle
  logic rr_q_r; // receive ready, last cycle
  logic fr_q_r; // frame ready, last cycle
  logic win_r; // received data window open
  logic hold_r; // latest demodulated bit
  logic dat_r; // data presented on the data source
  logic [2:0] bcnt_r; // bit clock half period counter
  logic bclk_r; // bit clock level
  logic io2_s1_r; // pin synchroniser, first stage
  logic io2_s2_r; // pin synchroniser, second stage
  logic tx_bit_r;
  logic tx_vld_r;
  logic [5:0] io_r;
  logic [5:0] oe_r;

  // decode of the register port
  wire sel_pat = addr_i >= sdr_pkg::A_PAT0 && addr_i <= sdr_pkg::A_PAT7;
  wire [2:0] pat_idx = 3'(addr_i - sdr_pkg::A_PAT0);
  wire [2:0] mode = op_r[sdr_pkg::OP_MODE_LSB +: 3];
  wire cont = op_r[sdr_pkg::OP_CONT_BIT];
  wire bsync = op_r[sdr_pkg::OP_BSYNC_BIT];
  wire in_rx = mode == sdr_pkg::M_RX;
  wire in_tx = mode == sdr_pkg::M_TX;
  wire was_rx = prev_mode_r == sdr_pkg::M_RX;
  wire was_tx = prev_mode_r == sdr_pkg::M_TX;
  wire was_idle = prev_mode_r == sdr_pkg::M_SLEEP ||
    prev_mode_r == sdr_pkg::M_STDBY;
  wire [2:0] len_m1 = sync_r[sdr_pkg::SYNC_LEN_LSB +: 3];
  wire [2:0] tol = sync_r[sdr_pkg::SYNC_TOL_LSB +: 3];
  wire [63:0] pattern = {pat_r[0], pat_r[1], pat_r[2], pat_r[3],
    pat_r[4], pat_r[5], pat_r[6], pat_r[7]};

  // queue clears: idle to receive, receive to transmit, leaving transmit
  wire mode_chg = mode != prev_mode_r;
  wire qclr_nxt = mode_chg && ((was_idle && in_rx) ||
    (was_rx && in_tx) || was_tx);

  // correlator: pattern packet mode needs no synchroniser bit
  wire det_on = in_rx && sync_r[sdr_pkg::SYNC_EN_BIT] &&
    (!cont || bsync);
  wire det_step = det_on && rx_bit_vld_i;
  wire [63:0] shift_nxt = {shift_r[62:0], rx_bit_i};
  wire [5:0] drop = 6'({3'h7 - len_m1, 3'h0});
  // first byte bit 7 lands on the oldest bit of the window
  wire [63:0] ref_bits = pattern >> drop;
  wire [63:0] ref_mask = 64'hffff_ffff_ffff_ffff >> drop;
  wire [6:0] need = 7'({len_m1, 3'h0}) + 7'h08;
  wire [6:0] errs = ones((shift_nxt ^ ref_bits) & ref_mask);
  wire hit = det_step && (nbits_r + 7'h01 >= need) &&
    errs <= 7'(tol);
  wire leave_rx = was_rx && !in_rx;
  wire q_emptied = nemp_q_r && !stat_i.queue_nonempty;
  // a hit in the same cycle as a clear keeps the flag set
  wire match_nxt = hit || (match_r && !leave_rx && !q_emptied);

  // packet receive data window between the two rising edges
  wire rr_rise = stat_i.receive_ready && !rr_q_r;
  wire fr_rise = stat_i.frame_ready && !fr_q_r;
  wire win_nxt = rr_rise || (win_r && !fr_rise);

  // bit clock: runs in continuous transmit, and receive with synchroniser
  wire bclk_on = cont && (in_tx || (in_rx && bsync));
  wire bclk_tgl = bclk_on && bcnt_r == HALF_M1;
  wire tx_cap = in_tx && bclk_r && bcnt_r == HALF_M1 - 3'h1;
  wire bclk_fall = bclk_tgl && bclk_r;
  wire [2:0] bcnt_nxt = (!bclk_on || bclk_tgl) ? 3'h0 : bcnt_r + 3'h1;
  // data: cleaned data moves on falling clock, raw data follows the demod
  wire dat_nxt = (cont && bsync) ? (bclk_fall ? hold_r : dat_r) :
    hold_r;
  wire pkt_dat = in_rx ? (dat_r && win_r) : stat_i.tx_data;

  // source vector, indexed by the source enumeration
  wire [17:0] src_vec = {
    stat_i.frame_ready, stat_i.frame_sent, stat_i.checksum_good,
    stat_i.queue_threshold_hit, stat_i.queue_nonempty, stat_i.queue_full,
    stat_i.transmit_ready, stat_i.receive_ready, match_r,
    bclk_r && bclk_on, cont ? dat_r : pkt_dat, stat_i.rssi,
    stat_i.timeout, stat_i.auto_sequence_active, stat_i.synth_locked,
    stat_i.reference_clock_out, stat_i.mode_settled, 1'b0};
  wire [11:0] codes = {map_b_r[5:4], map_b_r[7:6], map_a_r[1:0],
    map_a_r[3:2], map_a_r[5:4], map_a_r[7:6]};
  logic [5:0] io_nxt;
  for (genvar k = 0; k < 6; k++) begin : g_route
    wire [29:0] row = route_row(cont, mode, codes[2*k +: 2]);
    assign io_nxt[k] = src_vec[row[5*k +: 5]];
  end
  // line 2 turns round to an input only in continuous transmit
  wire [5:0] oe_nxt = {3'h7, !(cont && in_tx), 2'h3};

  // events and interrupt: set wins over a write-one clear
  wire [1:0] ev = {qclr_nxt, hit && !match_r};
  wire wr_ist = wr_i && addr_i == sdr_pkg::A_IRQ_ST;
  wire [1:0] ist_nxt = ev | (ist_r & ~(wr_ist ? wdata_i[1:0] : 2'h0));

  // read mux, unmapped addresses read zero
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    if (sel_pat) begin
      rd_mux = pat_r[pat_idx];
    end else begin
      case (addr_i)
        sdr_pkg::A_OPMODE: rd_mux = op_r;
        sdr_pkg::A_SYNC: rd_mux = sync_r;
        sdr_pkg::A_MAP_A: rd_mux = map_a_r;
        sdr_pkg::A_MAP_B: rd_mux = map_b_r;
        sdr_pkg::A_IRQ_ST: rd_mux = {6'h00, ist_r};
        sdr_pkg::A_IRQ_MSK: rd_mux = {6'h00, imsk_r};
        sdr_pkg::A_STATUS: rd_mux = {win_r, match_r, 3'h0, mode};
        default: rd_mux = 8'h00;
      endcase
    end
  end

  // configuration registers; pattern bytes trust the host not to use zero
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      op_r <= sdr_pkg::OP_RST;
      sync_r <= sdr_pkg::SYNC_RST;
      map_a_r <= sdr_pkg::MAP_RST;
      map_b_r <= sdr_pkg::MAP_RST;
      imsk_r <= sdr_pkg::IRQ_RST;
      for (int i = 0; i < 8; i++) begin
        pat_r[i] <= sdr_pkg::PAT_RST;
      end
    end else if (wr_i) begin
      if (sel_pat) begin
        pat_r[pat_idx] <= wdata_i;
      end
      if (addr_i == sdr_pkg::A_OPMODE) op_r <= {3'h0, wdata_i[4:0]};
      if (addr_i == sdr_pkg::A_SYNC) sync_r <= wdata_i;
      if (addr_i == sdr_pkg::A_MAP_A) map_a_r <= wdata_i;
      if (addr_i == sdr_pkg::A_MAP_B) map_b_r <= {wdata_i[7:4], 4'h0};
      if (addr_i == sdr_pkg::A_IRQ_MSK) imsk_r <= wdata_i[1:0];
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      rdata_r <= 8'h00;
      ist_r <= sdr_pkg::IRQ_RST;
      irq_r <= 1'b0;
    end else begin
      rdata_r <= rd_i ? rd_mux : 8'h00;
      ist_r <= ist_nxt;
      irq_r <= |(ist_nxt & imsk_r);
    end
  end

  // mode tracking, queue clear and correlator
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      prev_mode_r <= sdr_pkg::OP_RST[2:0];
      qclr_r <= 1'b0;
      shift_r <= 64'h0;
      nbits_r <= 7'h00;
      match_r <= 1'b0;
      nemp_q_r <= 1'b0;
    end else begin
      prev_mode_r <= mode;
      qclr_r <= qclr_nxt;
      nemp_q_r <= stat_i.queue_nonempty;
      match_r <= match_nxt;
      // window restarts whenever the detector is off, so stale bits
      // from an earlier reception can never complete a match
      if (!det_on) begin
        shift_r <= 64'h0;
        nbits_r <= 7'h00;
      end else if (det_step) begin
        shift_r <= shift_nxt;
        if (nbits_r != 7'h40) nbits_r <= nbits_r + 7'h01;
      end
    end
  end

  // ready edges, data window and demodulated data
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      rr_q_r <= 1'b0;
      fr_q_r <= 1'b0;
      win_r <= 1'b0;
      hold_r <= 1'b0;
      dat_r <= 1'b0;
    end else begin
      rr_q_r <= stat_i.receive_ready;
      fr_q_r <= stat_i.frame_ready;
      win_r <= win_nxt;
      if (rx_bit_vld_i) hold_r <= rx_bit_i;
      dat_r <= dat_nxt;
    end
  end

  // bit clock divider and transmit capture through the pin synchroniser
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      bcnt_r <= 3'h0;
      bclk_r <= 1'b0;
      io2_s1_r <= 1'b0;
      io2_s2_r <= 1'b0;
      tx_bit_r <= 1'b0;
      tx_vld_r <= 1'b0;
    end else begin
      bcnt_r <= bcnt_nxt;
      bclk_r <= bclk_on && (bclk_r ^ bclk_tgl);
      io2_s1_r <= io2_i;
      io2_s2_r <= io2_s1_r;
      // capture late in the high half: the io register and the two-flop
      // delay make this the pin level just before its clock rises
      tx_vld_r <= tx_cap;
      if (tx_cap) tx_bit_r <= io2_s2_r;
    end
  end

  // io line registers
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      io_r <= 6'h00;
      oe_r <= 6'h3f;
    end else begin
      io_r <= io_nxt;
      oe_r <= oe_nxt;
    end
  end

  assign rdata_o = rdata_r;
  assign irq_o = irq_r;
  assign io_o = io_r;
  assign io_oe_o = oe_r;
  assign queue_clear_o = qclr_r;
  assign sync_match_o = match_r;
  assign tx_bit_o = tx_bit_r;
  assign tx_bit_vld_o = tx_vld_r;
  // packet transmitter sends len_m1+1 bytes of the same pattern
  assign sync_cfg_o = {sync_r[sdr_pkg::SYNC_EN_BIT], len_m1, tol,
    pattern};

endmodule : sdr_sync_io

// ===== sdr_sync_io_checker.sv
// sdr_sync_io_checker: concurrent checks on the ports of sdr_sync_io.
// assumes one clock, sync reset, and the register map of sdr_pkg.
`timescale 1ns/100ps
module sdr_sync_io_checker (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [4:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic irq_o,
  input wire sdr_pkg::sdr_stat_t stat_i,
  input wire logic rx_bit_vld_i,
  input wire logic [5:0] io_o,
  input wire logic [5:0] io_oe_o,
  input wire logic queue_clear_o,
  input wire logic sync_match_o,
  input wire logic tx_bit_vld_o
);
  logic [7:0] op_r; // shadow of the mode register
  logic [7:0] mapa_r; // shadow of route register a
  logic [7:0] mapb_r; // shadow of route register b
  logic msk_r; // shadow of the match mask bit
  logic [2:0] om; // mode before a write
  logic [2:0] nm; // mode being written
  logic op_wr; // a write that really changes the mode
  logic clr_exp; // transition that must empty the queue
  logic keep_exp; // transition that must keep the queue
  logic pk_q; // packet mode, lines 3..1 on code 00
  logic idle0; // packet sleep, standby and fs modes, line 0 has no source
  logic set11; // continuous, lines 0 and 5 on code 11
  logic rxc; // continuous receive with bit sync and clock on line 1
  assign om = op_r[2:0];
  assign nm = wdata_i[2:0];
  assign op_wr = wr_i && addr_i == sdr_pkg::A_OPMODE && nm != om;
  assign clr_exp = (nm == sdr_pkg::M_RX && om <= sdr_pkg::M_STDBY) ||
    (om == sdr_pkg::M_RX && nm == sdr_pkg::M_TX) || om == sdr_pkg::M_TX;
  assign keep_exp = (om <= sdr_pkg::M_STDBY && nm <= sdr_pkg::M_STDBY) ||
    (om <= sdr_pkg::M_STDBY && nm == sdr_pkg::M_TX) ||
    (om == sdr_pkg::M_RX && nm <= sdr_pkg::M_STDBY);
  assign pk_q = !op_r[3] && mapa_r[5:0] == 6'h00;
  assign idle0 = !op_r[3] && om <= sdr_pkg::M_FS && mapa_r[7:6] == 2'h0;
  assign set11 = op_r[3] && mapa_r[7:6] == 2'h3 && mapb_r[5:4] == 2'h3;
  assign rxc = op_r[4:0] == 5'h1c && mapa_r[5:4] == 2'h0;
  // shadows follow writes at the same edge as the block's registers
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      op_r <= sdr_pkg::OP_RST;
      mapa_r <= sdr_pkg::MAP_RST;
      mapb_r <= sdr_pkg::MAP_RST;
      msk_r <= 1'b0;
    end else if (wr_i) begin
      if (addr_i == sdr_pkg::A_OPMODE) op_r <= wdata_i;
      if (addr_i == sdr_pkg::A_MAP_A) mapa_r <= wdata_i;
      if (addr_i == sdr_pkg::A_MAP_B) mapb_r <= wdata_i;
      if (addr_i == sdr_pkg::A_IRQ_MSK) msk_r <= wdata_i[0];
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  qclr_set_a: assert property (op_wr && clr_exp |-> ##2 queue_clear_o)
    else $error("queue not emptied on mode change");
  qclr_keep_a: assert property (op_wr && keep_exp |-> ##2 !queue_clear_o)
    else $error("queue emptied on a keeping mode change");
  qclr_pulse_a: assert property (queue_clear_o |=> !queue_clear_o)
    else $error("queue clear longer than one cycle");
  match_cause_a: assert property ($rose(sync_match_o) |-> $past(rx_bit_vld_i))
    else $error("match without a new bit");
  match_leave_a: assert property (op_wr && om == sdr_pkg::M_RX |-> ##[1:3] !sync_match_o)
    else $error("match kept after leaving receive");
  match_empty_a: assert property ($fell(stat_i.queue_nonempty) |-> ##[1:2] !sync_match_o)
    else $error("match kept after queue emptied");
  irq_match_a: assert property ($rose(sync_match_o) && msk_r |-> irq_o)
    else $error("unmasked match did not raise irq");
  rd_quiet_a: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data outside read cycle");
  oe_fixed_a: assert property (io_oe_o[5:3] == 3'h7 && io_oe_o[1:0] == 2'h3)
    else $error("output line released");
  bclk_shape_a: assert property (tx_bit_vld_o |-> !$past(io_o[1], 3) && $past(io_o[1], 2) && $past(io_o[1]) && io_o[1] ##1 io_o[1] ##1 !io_o[1])
    else $error("bit clock shape wrong");
  bclk_period_a: assert property (tx_bit_vld_o |=> !tx_bit_vld_o [*7])
    else $error("bit capture spacing wrong");
  pkt_queue_a: assert property ($past(reset_n_i) && $past(pk_q) |-> io_o[3:1] == $past({stat_i.queue_full, stat_i.queue_nonempty, stat_i.queue_threshold_hit}))
    else $error("queue flags not on lines 3..1");
  idle_low_a: assert property ($past(reset_n_i) && $past(idle0) |-> !io_o[0])
    else $error("unrouted line 0 not low");
  settled_a: assert property ($past(reset_n_i) && $past(set11) |-> {io_o[5], io_o[0]} == {2{$past(stat_i.mode_settled)}})
    else $error("settled flag not on lines 0 and 5");
  rx_fall_a: assert property ($past(rxc, 2) && rxc && $changed(io_o[2]) |-> $fell(io_o[1]))
    else $error("receive data moved off falling clock");
endmodule : sdr_sync_io_checker
bind sdr_sync_io sdr_sync_io_checker chk (
  .clk_i, .reset_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .irq_o,
  .stat_i, .rx_bit_vld_i, .io_o, .io_oe_o, .queue_clear_o, .sync_match_o,
  .tx_bit_vld_o
);

// ===== tb_sdr_sync_io.sv
// tb_sdr_sync_io: self-checking bench for sdr_sync_io with a host model.
// assumes the checker binds itself to the design.
`timescale 1ns/100ps
module tb_sdr_sync_io;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [4:0] addr_i = 5'h00;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic rx_bit_i = 1'b0;
  logic rx_bit_vld_i = 1'b0;
  sdr_pkg::sdr_stat_t stat_i = '0;
  logic host_en = 1'b0; // host drives line 2
  logic [7:0] host_byte = 8'h00; // bits the host sends
  logic host_dat;
  logic io2_i; // resolved level of io line 2
  logic [7:0] rdata_o;
  logic irq_o;
  logic [5:0] io_o;
  logic [5:0] io_oe_o;
  logic queue_clear_o;
  logic sync_match_o;
  logic tx_bit_o;
  logic tx_bit_vld_o;
  sdr_pkg::sdr_sync_cfg_t sync_cfg_o;
  int mismatches = 0;
  int checked = 0;
  // mode walk and whether each step empties the queue (bit i)
  localparam logic [7:0] MSEQ [9] = '{8'h00, 8'h01, 8'h03, 8'h01, 8'h04,
    8'h03, 8'h00, 8'h04, 8'h01};
  localparam logic [8:0] CLR = 9'h0f8;
  always #50 clk_i = ~clk_i;
  // the device wins the line whenever it enables its driver
  assign io2_i = io_oe_o[2] ? io_o[2] : host_dat;
  sdr_sync_io dut (.clk_i, .reset_n_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o, .irq_o, .stat_i, .rx_bit_i, .rx_bit_vld_i, .io2_i, .io_o,
    .io_oe_o, .queue_clear_o, .sync_match_o, .tx_bit_o, .tx_bit_vld_o,
    .sync_cfg_o);
  sdr_host_model host (.clk_i, .reset_n_i, .dclk_i(io_o[1]),
    .en_i(host_en), .byte_i(host_byte), .data_o(host_dat));
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick
  task automatic cmp(input string nm, input logic [63:0] exp, got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : cmp
  // one write cycle, then an idle cycle so strobes never merge
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    @(posedge clk_i);
  endtask : wr
  // data stands only in the cycle after the strobe
  task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(posedge clk_i);
    cmp("read data", exp, rdata_o);
  endtask : rd_chk
  task automatic results;
    if (mismatches == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results
  task automatic s_regs;
    rd_chk(sdr_pkg::A_OPMODE, sdr_pkg::OP_RST);
    rd_chk(sdr_pkg::A_SYNC, sdr_pkg::SYNC_RST);
    rd_chk(sdr_pkg::A_PAT7, sdr_pkg::PAT_RST);
    rd_chk(sdr_pkg::A_MAP_A, sdr_pkg::MAP_RST);
    rd_chk(5'h1f, 8'h00);
    wr(sdr_pkg::A_MAP_B, 8'hff);
    rd_chk(sdr_pkg::A_MAP_B, 8'hf0);
    wr(sdr_pkg::A_MAP_B, 8'h00);
    wr(sdr_pkg::A_PAT7, 8'h3e);
    wr(sdr_pkg::A_PAT0, 8'h2d);
    wr(5'h03, 8'h96);
    cmp("pattern", 64'h2d9601010101013e, sync_cfg_o.pattern);
  endtask : s_regs
  task automatic s_modes;
    for (int i = 0; i < 9; i++) begin
      wr(sdr_pkg::A_OPMODE, MSEQ[i]);
      tick(1);
      cmp("queue clear", CLR[i], queue_clear_o);
    end
  endtask : s_modes
  // enter a mode, shift bits in oldest first, judge the flag, leave
  task automatic trial(input logic [7:0] op, sc, input logic [15:0] b,
    input int n, input logic exp);
    wr(sdr_pkg::A_SYNC, sc);
    wr(sdr_pkg::A_OPMODE, op);
    for (int i = n - 1; i >= 0; i--) begin
      rx_bit_i <= b[i];
      rx_bit_vld_i <= 1'b1;
      @(posedge clk_i);
      rx_bit_vld_i <= 1'b0;
      @(posedge clk_i);
    end
    cmp("sync match", exp, sync_match_o);
    wr(sdr_pkg::A_OPMODE, 8'h01);
    tick(3);
  endtask : trial
  task automatic s_sync;
    trial(8'h04, 8'h80, 16'h002d, 8, 1'b1);
    trial(8'h04, 8'h80, 16'h00b4, 8, 1'b0);
    trial(8'h04, 8'h80, 16'h002c, 8, 1'b0);
    trial(8'h04, 8'h81, 16'h002c, 8, 1'b1);
    trial(8'h04, 8'h87, 16'h00d3, 8, 1'b1);
    trial(8'h04, 8'h87, 16'h00d2, 8, 1'b0);
    trial(8'h04, 8'h00, 16'h002d, 8, 1'b0);
    trial(8'h0c, 8'h80, 16'h002d, 8, 1'b0);
    trial(8'h1c, 8'h80, 16'h002d, 8, 1'b1);
    trial(8'h04, 8'h88, 16'h2d96, 16, 1'b1);
    trial(8'h04, 8'h88, 16'h962d, 16, 1'b0);
  endtask : s_sync
  task automatic s_irq;
    wr(sdr_pkg::A_IRQ_ST, 8'h03);
    wr(sdr_pkg::A_IRQ_MSK, 8'h01);
    trial(8'h04, 8'h80, 16'h002d, 8, 1'b1);
    cmp("irq", 1'b1, irq_o);
    rd_chk(sdr_pkg::A_IRQ_ST, 8'h03);
    wr(sdr_pkg::A_IRQ_ST, 8'h01);
    tick(1);
    cmp("irq", 1'b0, irq_o);
    rd_chk(sdr_pkg::A_IRQ_ST, 8'h02);
    wr(sdr_pkg::A_IRQ_MSK, 8'h00);
    trial(8'h04, 8'h80, 16'h002d, 8, 1'b1);
    cmp("irq", 1'b0, irq_o);
  endtask : s_irq
  // continuous transmit: host sends one byte on the device's clock
  task automatic s_ctx;
    int k;
    host_byte <= 8'h4b;
    host_en <= 1'b1;
    wr(sdr_pkg::A_OPMODE, 8'h0b);
    for (int i = 7; i >= 0; i--) begin
      for (k = 0; k < 20 && tx_bit_vld_o !== 1'b1; k++) @(posedge clk_i);
      cmp("tx bit", host_byte[i], tx_bit_o);
      @(posedge clk_i);
    end
    tick(8);
    cmp("line 2 enable", 1'b0, io_oe_o[2]);
    wr(sdr_pkg::A_OPMODE, 8'h01);
    host_en <= 1'b0;
  endtask : s_ctx
  task automatic s_route;
    wr(sdr_pkg::A_MAP_A, 8'hc0);
    wr(sdr_pkg::A_MAP_B, 8'h30);
    wr(sdr_pkg::A_OPMODE, 8'h0c);
    stat_i.mode_settled <= 1'b1;
    tick(2);
    cmp("settled lines", 2'h3, {io_o[5], io_o[0]});
    wr(sdr_pkg::A_MAP_A, 8'h04);
    wr(sdr_pkg::A_OPMODE, 8'h04);
    rx_bit_i <= 1'b1;
    tick(2);
    cmp("rx data", 1'b0, io_o[2]);
    stat_i.receive_ready <= 1'b1;
    tick(3);
    cmp("rx data", 1'b1, io_o[2]);
    stat_i.frame_ready <= 1'b1;
    tick(3);
    cmp("rx data", 1'b0, io_o[2]);
    wr(sdr_pkg::A_MAP_A, 8'h00);
    stat_i <= '0;
    stat_i.checksum_good <= 1'b1;
    stat_i.queue_full <= 1'b1;
    tick(2);
    cmp("line 0", 1'b1, io_o[0]);
    cmp("lines 3..1", 3'h4, io_o[3:1]);
    wr(sdr_pkg::A_OPMODE, 8'h03);
    stat_i.frame_sent <= 1'b1;
    tick(2);
    cmp("line 0", 1'b1, io_o[0]);
    wr(sdr_pkg::A_OPMODE, 8'h01);
    tick(2);
    cmp("line 0", 1'b0, io_o[0]);
  endtask : s_route
  initial begin
    repeat (20) @(posedge clk_i);
    reset_n_i <= 1'b1;
    tick(2);
    s_regs;
    s_modes;
    s_sync;
    s_irq;
    s_ctx;
    s_route;
    results;
  end
  // the whole run needs well under a thousand cycles; this cuts a hang short
  initial begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    results;
  end
endmodule : tb_sdr_sync_io
